// ### rtl/isc_pkg.sv
// Shared constants and types for the instrument status and configuration block.
package isc_pkg;

	// Clock and timing.
	localparam int unsigned CLK_HZ      = 25_000_000;
	localparam int unsigned REPEAT_MS   = 250;
	localparam int unsigned REPEAT_CYC  = CLK_HZ / 1000 * REPEAT_MS;
	localparam int unsigned ACT_MS      = 50;
	localparam int unsigned ACT_CYC     = CLK_HZ / 1000 * ACT_MS;
	localparam int unsigned ERR_MS      = 200;
	localparam int unsigned ERR_CYC     = CLK_HZ / 1000 * ERR_MS;
	localparam int unsigned CNT_W       = 24;

	// Status byte bit positions.
	localparam int unsigned ST_MAG_LOW  = 0;
	localparam int unsigned ST_PARAM    = 1;
	localparam int unsigned ST_NO_REF   = 2;
	localparam int unsigned ST_UNLOCK   = 3;
	localparam int unsigned ST_OVERLOAD_LAMP     = 4;
	localparam int unsigned ST_AOFS     = 5;
	localparam int unsigned ST_SRQ      = 6;
	localparam int unsigned ST_ILLEGAL  = 7;

	// Sensitivity indices, 1-2-5 steps, 100 nV = 4 through 500 mV = 24.
	localparam logic [4:0] SENS_MIN     = 5'h04;
	localparam logic [4:0] SENS_MAX     = 5'h18;
	localparam logic [4:0] LOW_MIN      = 5'h07;
	localparam logic [4:0] NORM_MAX     = 5'h15;
	localparam logic [4:0] HIGH_MAX     = 5'h12;

	// Switch bank field positions.
	localparam int unsigned SW1_ECHO    = 5;
	localparam logic [4:0] ADDR_INVALID = 5'h1f;
	localparam int unsigned SW2_ODD     = 3;
	localparam int unsigned SW2_PAR_EN  = 4;
	localparam int unsigned SW2_ECHO    = 5;
	localparam int unsigned SW2_STOP2   = 6;

	// Baud divisor: fastest rate, then halved per step down to 300.
	localparam int unsigned BAUD_MAX    = 19200;
	localparam int unsigned BAUD_DIV_W  = 17;
	localparam logic [BAUD_DIV_W-1:0] BAUD_BASE_DIV = BAUD_DIV_W'(CLK_HZ / BAUD_MAX);
	localparam logic [2:0] BAUD_SHIFT_MAX = 3'h6;

	// Front-panel key indices.
	localparam int unsigned KEY_SENS_UP = 0;
	localparam int unsigned KEY_SENS_DN = 1;
	localparam int unsigned KEY_RES_UP  = 2;
	localparam int unsigned KEY_RES_DN  = 3;
	localparam int unsigned KEY_FILT0   = 4;
	localparam int unsigned KEY_DISP_UP = 7;
	localparam int unsigned KEY_N       = 8;
	localparam int unsigned FILT_N      = 3;

	typedef enum logic [1:0] {RES_LOW, RES_NORM, RES_HIGH} isc_res_t;
	typedef enum logic [1:0] {REM_LOCAL, REM_REMOTE, REM_LOCKOUT} isc_rem_t;
	typedef enum logic [2:0] {
		CMD_SET_MASK,
		CMD_SET_REMOTE,
		CMD_SET_SENS,
		CMD_SET_RESERVE,
		CMD_ILLEGAL
	} isc_cmd_t;

	localparam logic [4:0] SENS_RST = SENS_MAX;
	localparam logic [7:0] MASK_RST = 8'h00;
endpackage

// ### rtl/isc_top.sv
// Status byte, configuration switches and front-panel control of the instrument.
`timescale 1ns/100ps
// Notes on behaviour
// - Status bits 0,2,3,4,5 report measurement conditions.
// - Bits 1,6,7 flag range, request, illegal.
// - Switch banks sampled continuously, applied immediately.
// - Bus address from address bank positions 1-5.
// - Address position six down echoes bus traffic.
// - Serial positions 1-3 select baud rate.
// - Position five enables parity, four picks odd.
// - Position six down echoes received serial characters.
// - Position seven up gives two stop bits.
// - Eight data bits sent, top bit zero.
// - Sensitivity keys step, repeat four per second.
// - Sensitivity limited to 100 nV..500 mV.
// - Reserve moved to next allowed on sensitivity.
// - Reserve ranges: low, normal, high limits.
// - Filter keys toggle, one lamp of two lit.
// - Bandpass centre is reference, or double.
// - Traffic lamp pulses on every host character.
// - Error lamp flashes on host interface error.
// - Lockout lights remote lamp, ignores all keys.
// - Remote ignores keys except display-up, returns local.
// - Host writes request mask, device stores it.
// - Host code 0,1,2 picks local/remote/lockout.
module isc_top
#(
	parameter int unsigned FREQ_W      = 20,
	parameter int unsigned REPEAT_CYCLES = isc_pkg::REPEAT_CYC,
	parameter int unsigned ACT_CYCLES  = isc_pkg::ACT_CYC,
	parameter int unsigned ERR_CYCLES  = isc_pkg::ERR_CYC
)
(
	// Clock and reset.
	input  wire logic                         mclk_i,
	input  wire logic                         sys_rst_i,
	// Rear switch banks and front keys (pins, synchronised).
	input  wire logic [7:0]                   address_switch_bank_i,
	input  wire logic [7:0]                   serial_switch_bank_i,
	input  wire logic [isc_pkg::KEY_N-1:0]    panel_keys_i,
	// Measurement conditions from the analog side.
	input  wire logic                         mag_low_i,
	input  wire logic                         no_ref_i,
	input  wire logic                         unlocked_i,
	input  wire logic                         overload_i,
	input  wire logic                         auto_offset_fail_i,
	input  wire logic                         ref_double_i,
	input  wire logic [FREQ_W-1:0]            ref_freq_i,
	// Decoded host commands and character events.
	input  wire logic                         cmd_valid_i,
	input  wire isc_pkg::isc_cmd_t            cmd_code_i,
	input  wire logic [7:0]                   cmd_value_i,
	input  wire logic                         status_clear_i,
	input  wire logic                         rx_char_i,
	input  wire logic                         tx_valid_i,
	input  wire logic [7:0]                   tx_char_i,
	// Status and settings.
	output logic [7:0]                        instrument_status_flags_o,
	output logic [7:0]                        srq_mask_o,
	output logic                              srq_o,
	output logic [4:0]                        sensitivity_o,
	output isc_pkg::isc_res_t                 dynamic_reserve_o,
	output isc_pkg::isc_rem_t                 remote_state_o,
	output logic [FREQ_W:0]                   bandpass_freq_o,
	// Link configuration.
	output logic [4:0]                        bus_addr_o,
	output logic                              bus_addr_ok_o,
	output logic                              debug_echo_o,
	output logic [isc_pkg::BAUD_DIV_W-1:0]    baud_div_o,
	output logic                              parity_en_o,
	output logic                              parity_odd_o,
	output logic                              serial_echo_o,
	output logic                              two_stop_o,
	output logic                              tx_valid_o,
	output logic [7:0]                        tx_data_o,
	// Lamps.
	output logic [isc_pkg::FILT_N-1:0]        filter_in_lamp_o,
	output logic [isc_pkg::FILT_N-1:0]        filter_out_lamp_o,
	output logic                              overload_lamp_o,
	output logic                              loop_unlocked_lamp_o,
	output logic                              traffic_lamp_o,
	output logic                              error_lamp_o,
	output logic                              remote_lamp_o
);
	import isc_pkg::*;

	typedef struct packed {
		logic [7:0]            s1a, s1b, s2a, s2b;
		logic [KEY_N-1:0]      ka, kb, kp;
		logic [7:0]            status, mask;
		logic                  srq;
		logic [4:0]            sens;
		isc_res_t              res;
		isc_rem_t              remote_lamp;
		logic [FILT_N-1:0]     filt, filt_out;
		logic [CNT_W-1:0]      rpt, act, err;
		logic                  act_lamp, err_lamp, ovl_lamp, unl_lamp, rem_lamp;
		logic [4:0]            addr;
		logic                  addr_ok, dbg_echo;
		logic [BAUD_DIV_W-1:0] baud_div;
		logic                  par_en, par_odd, ser_echo, stop2;
		logic                  tx_valid;
		logic [7:0]            tx_data;
		logic [FREQ_W:0]       bp_freq;
	} isc_st_t;

	isc_st_t st_r;
	isc_st_t st_nxt;

	// Whether a reserve setting may be used at a sensitivity index.
	function automatic logic res_ok(input isc_res_t r, input logic [4:0] s);
		case (r)
			RES_LOW:  res_ok = (s >= LOW_MIN);
			RES_NORM: res_ok = (s <= NORM_MAX);
			RES_HIGH: res_ok = (s <= HIGH_MAX);
			default:  res_ok = 1'b0;
		endcase
	endfunction

	// Next allowed reserve once the sensitivity has moved.
	function automatic isc_res_t res_fix(input isc_res_t r, input logic [4:0] s);
		isc_res_t t;
		t = r;
		if (t == RES_HIGH && s > HIGH_MAX)
			t = RES_NORM;
		if (t == RES_NORM && s > NORM_MAX)
			t = RES_LOW;
		if (t == RES_LOW && s < LOW_MIN)
			t = RES_NORM;
		res_fix = t;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic.
	always_comb
	begin
		logic [KEY_N-1:0] press;
		logic [2:0]       bsel;
		logic [4:0]       s_new;
		logic             s_step;
		logic             s_up;
		logic             host_err;
		logic [7:0]       rise;
		press    = '0;
		bsel     = '0;
		s_new    = '0;
		s_step   = 1'b0;
		s_up     = 1'b0;
		host_err = 1'b0;
		rise     = '0;
		st_nxt   = st_r;
		// Two-flop synchronisers on switches and keys.
		st_nxt.s1a = address_switch_bank_i;
		st_nxt.s1b = st_r.s1a;
		st_nxt.s2a = serial_switch_bank_i;
		st_nxt.s2b = st_r.s2a;
		st_nxt.ka  = panel_keys_i;
		st_nxt.kb  = st_r.ka;
		st_nxt.kp  = st_r.kb;
		// Switch decode follows the banks every cycle.
		st_nxt.addr     = st_r.s1b[4:0];
		st_nxt.addr_ok  = (st_r.s1b[4:0] != ADDR_INVALID);
		st_nxt.dbg_echo = ~st_r.s1b[SW1_ECHO];
		bsel = ~st_r.s2b[2:0];
		if (bsel > BAUD_SHIFT_MAX)
			bsel = BAUD_SHIFT_MAX;
		st_nxt.baud_div = BAUD_BASE_DIV << bsel;
		st_nxt.par_en   = st_r.s2b[SW2_PAR_EN];
		st_nxt.par_odd  = st_r.s2b[SW2_ODD];
		st_nxt.ser_echo = ~st_r.s2b[SW2_ECHO];
		st_nxt.stop2    = st_r.s2b[SW2_STOP2];
		// Outgoing characters keep eight bits with the top bit clear.
		st_nxt.tx_valid = tx_valid_i;
		if (tx_valid_i)
			st_nxt.tx_data = {1'b0, tx_char_i[6:0]};
		// Key presses, gated by the remote state.
		press = st_r.kb & ~st_r.kp;
		case (st_r.remote_lamp)
			REM_LOCAL:   ;
			REM_REMOTE:
			begin
				if (press[KEY_DISP_UP])
					st_nxt.remote_lamp = REM_LOCAL;
				press = '0;
			end
			REM_LOCKOUT: press = '0;
			default:     press = '0;
		endcase
		// Sensitivity keys with auto-repeat while held.
		if (press[KEY_SENS_UP] || press[KEY_SENS_DN])
		begin
			s_step    = 1'b1;
			s_up      = press[KEY_SENS_UP];
			st_nxt.rpt = CNT_W'(REPEAT_CYCLES - 1);
		end
		else if (st_r.remote_lamp == REM_LOCAL && (st_r.kb[KEY_SENS_UP] ^ st_r.kb[KEY_SENS_DN]))
		begin
			if (st_r.rpt == '0)
			begin
				s_step    = 1'b1;
				s_up      = st_r.kb[KEY_SENS_UP];
				st_nxt.rpt = CNT_W'(REPEAT_CYCLES - 1);
			end
			else
				st_nxt.rpt = st_r.rpt - 1'b1;
		end
		s_new = st_r.sens;
		if (s_step && s_up && st_r.sens < SENS_MAX)
			s_new = st_r.sens + 1'b1;
		else if (s_step && !s_up && st_r.sens > SENS_MIN)
			s_new = st_r.sens - 1'b1;
		// Reserve keys accept only settings allowed at this sensitivity.
		if (press[KEY_RES_UP] && st_r.res != RES_HIGH && res_ok(isc_res_t'(st_r.res + 1'b1), s_new))
			st_nxt.res = isc_res_t'(st_r.res + 1'b1);
		else if (press[KEY_RES_DN] && st_r.res != RES_LOW && res_ok(isc_res_t'(st_r.res - 1'b1), s_new))
			st_nxt.res = isc_res_t'(st_r.res - 1'b1);
		// Filter keys toggle; the out lamp is the complement.
		st_nxt.filt = st_r.filt ^ press[KEY_FILT0 +: FILT_N];
		// Host commands.
		if (cmd_valid_i)
		begin
			case (cmd_code_i)
				CMD_SET_MASK:    st_nxt.mask = cmd_value_i;
				CMD_SET_REMOTE:
				begin
					if (cmd_value_i <= 8'h02)
						st_nxt.remote_lamp = isc_rem_t'(cmd_value_i[1:0]);
					else
						host_err = 1'b1;
				end
				CMD_SET_SENS:
				begin
					if (cmd_value_i >= {3'h0, SENS_MIN} && cmd_value_i <= {3'h0, SENS_MAX})
						s_new = cmd_value_i[4:0];
					else
						host_err = 1'b1;
				end
				CMD_SET_RESERVE:
				begin
					if (cmd_value_i <= 8'h02 && res_ok(isc_res_t'(cmd_value_i[1:0]), s_new))
						st_nxt.res = isc_res_t'(cmd_value_i[1:0]);
					else
						host_err = 1'b1;
				end
				default:         host_err = 1'b1;
			endcase
		end
		st_nxt.sens = s_new;
		st_nxt.res  = res_fix(st_nxt.res, s_new);
		st_nxt.filt_out = ~st_nxt.filt;
		// Status byte: sticky bits clear on read, a new event wins.
		if (status_clear_i)
		begin
			st_nxt.status[ST_PARAM]   = 1'b0;
			st_nxt.status[ST_SRQ]     = 1'b0;
			st_nxt.status[ST_ILLEGAL] = 1'b0;
			st_nxt.srq = 1'b0;
		end
		st_nxt.status[ST_MAG_LOW] = mag_low_i;
		st_nxt.status[ST_NO_REF]  = no_ref_i;
		st_nxt.status[ST_UNLOCK]  = unlocked_i;
		st_nxt.status[ST_OVERLOAD_LAMP]    = overload_i;
		st_nxt.status[ST_AOFS]    = auto_offset_fail_i;
		if (cmd_valid_i && cmd_code_i < CMD_ILLEGAL && host_err)
			st_nxt.status[ST_PARAM] = 1'b1;
		if (cmd_valid_i && cmd_code_i >= CMD_ILLEGAL)
			st_nxt.status[ST_ILLEGAL] = 1'b1;
		rise = st_nxt.status & ~st_r.status & st_r.mask;
		rise[ST_SRQ] = 1'b0;
		if (rise != '0)
		begin
			st_nxt.status[ST_SRQ] = 1'b1;
			st_nxt.srq = 1'b1;
		end
		// Traffic and error lamps are stretched pulses.
		if (rx_char_i || tx_valid_i)
			st_nxt.act = CNT_W'(ACT_CYCLES);
		else if (st_r.act != '0)
			st_nxt.act = st_r.act - 1'b1;
		if (cmd_valid_i && (host_err || cmd_code_i == CMD_ILLEGAL))
			st_nxt.err = CNT_W'(ERR_CYCLES);
		else if (st_r.err != '0)
			st_nxt.err = st_r.err - 1'b1;
		st_nxt.act_lamp = (st_nxt.act != '0);
		st_nxt.err_lamp = (st_nxt.err != '0);
		st_nxt.ovl_lamp = overload_i;
		st_nxt.unl_lamp = unlocked_i;
		st_nxt.rem_lamp = (st_nxt.remote_lamp != REM_LOCAL);
		// Bandpass centre tracks the demodulator frequency.
		st_nxt.bp_freq = ref_double_i ? {ref_freq_i, 1'b0} : {1'b0, ref_freq_i};
	end

	////////////////////////////////////////////////////////////////////////////
	// State register.
	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			st_r      <= '0;
			st_r.sens <= SENS_RST;
			st_r.res  <= RES_LOW;
			st_r.remote_lamp  <= REM_LOCAL;
			st_r.mask <= MASK_RST;
			st_r.filt_out <= '1;
			st_r.baud_div <= BAUD_BASE_DIV;
		end
		else
			st_r <= st_nxt;
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs straight from the state register.
	assign instrument_status_flags_o = st_r.status;
	assign srq_mask_o           = st_r.mask;
	assign srq_o                = st_r.srq;
	assign sensitivity_o        = st_r.sens;
	assign dynamic_reserve_o    = st_r.res;
	assign remote_state_o       = st_r.remote_lamp;
	assign bandpass_freq_o      = st_r.bp_freq;
	assign bus_addr_o           = st_r.addr;
	assign bus_addr_ok_o        = st_r.addr_ok;
	assign debug_echo_o         = st_r.dbg_echo;
	assign baud_div_o           = st_r.baud_div;
	assign parity_en_o          = st_r.par_en;
	assign parity_odd_o         = st_r.par_odd;
	assign serial_echo_o        = st_r.ser_echo;
	assign two_stop_o           = st_r.stop2;
	assign tx_valid_o           = st_r.tx_valid;
	assign tx_data_o            = st_r.tx_data;
	assign filter_in_lamp_o     = st_r.filt;
	assign filter_out_lamp_o    = st_r.filt_out;
	assign overload_lamp_o      = st_r.ovl_lamp;
	assign loop_unlocked_lamp_o = st_r.unl_lamp;
	assign traffic_lamp_o       = st_r.act_lamp;
	assign error_lamp_o         = st_r.err_lamp;
	assign remote_lamp_o        = st_r.rem_lamp;
endmodule

// ### verification/isc_chk.sv
// Port-level assertions for the status and configuration block.
`timescale 1ns/100ps
module isc_chk
(
	// Clock and reset.
	input wire logic                      mclk_i,
	input wire logic                      sys_rst_i,
	// Observed inputs.
	input wire logic                      mag_low_i,
	input wire logic                      no_ref_i,
	input wire logic                      unlocked_i,
	input wire logic                      overload_i,
	input wire logic                      auto_offset_fail_i,
	input wire logic                      cmd_valid_i,
	input wire isc_pkg::isc_cmd_t         cmd_code_i,
	input wire logic [7:0]                cmd_value_i,
	input wire logic                      rx_char_i,
	input wire logic                      tx_valid_i,
	input wire logic [7:0]                tx_char_i,
	// Observed outputs.
	input wire logic [7:0]                instrument_status_flags_o,
	input wire logic [7:0]                srq_mask_o,
	input wire logic                      srq_o,
	input wire logic [4:0]                sensitivity_o,
	input wire isc_pkg::isc_res_t         dynamic_reserve_o,
	input wire isc_pkg::isc_rem_t         remote_state_o,
	input wire logic                      tx_valid_o,
	input wire logic [7:0]                tx_data_o,
	input wire logic [isc_pkg::FILT_N-1:0] filter_in_lamp_o,
	input wire logic [isc_pkg::FILT_N-1:0] filter_out_lamp_o,
	input wire logic                      traffic_lamp_o,
	input wire logic                      error_lamp_o,
	input wire logic                      remote_lamp_o
);
	import isc_pkg::*;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);
	// A status bit other than the request bit rises under the mask in force before it.
	sequence s_masked_rise;
		|(instrument_status_flags_o & ~$past(instrument_status_flags_o)
			& $past(srq_mask_o) & 8'hbf);
	endsequence
	// Conditions, commands and lamps tied to their causes.
	a_cond_bits_follow: assert property (!$past(sys_rst_i) |->
		{instrument_status_flags_o[5:2], instrument_status_flags_o[0]} ==
		$past({auto_offset_fail_i, overload_i, unlocked_i, no_ref_i, mag_low_i}))
		else $error("condition bits do not follow inputs");
	a_srq_on_mask: assert property (s_masked_rise |-> srq_o && instrument_status_flags_o[6])
		else $error("service request not raised");
	a_illegal_flags: assert property (cmd_valid_i && cmd_code_i == CMD_ILLEGAL |=>
		instrument_status_flags_o[7] && error_lamp_o) else $error("illegal command not flagged");
	a_mask_stored: assert property (cmd_valid_i && cmd_code_i == CMD_SET_MASK |=>
		srq_mask_o == $past(cmd_value_i)) else $error("mask not stored");
	a_remote_code: assert property (cmd_valid_i && cmd_code_i == CMD_SET_REMOTE
		&& cmd_value_i <= 8'h02 |=> remote_state_o == $past(cmd_value_i[1:0]))
		else $error("remote state not taken");
	a_sens_range: assert property (sensitivity_o >= SENS_MIN && sensitivity_o <= SENS_MAX)
		else $error("sensitivity out of range");
	a_reserve_allowed: assert property ((dynamic_reserve_o != RES_HIGH ||
		sensitivity_o <= HIGH_MAX) && (dynamic_reserve_o != RES_NORM || sensitivity_o <= NORM_MAX)
		&& (dynamic_reserve_o != RES_LOW || sensitivity_o >= LOW_MIN))
		else $error("reserve not allowed at sensitivity");
	a_filter_one_lamp: assert property (filter_in_lamp_o == ~filter_out_lamp_o)
		else $error("filter lamps not complementary");
	a_tx_top_zero: assert property (tx_valid_i |=> tx_valid_o
		&& tx_data_o == {1'b0, $past(tx_char_i[6:0])}) else $error("serial byte wrong");
	a_traffic_blink: assert property (rx_char_i |=> traffic_lamp_o)
		else $error("traffic lamp not lit");
	a_remote_lamp_on: assert property ($past(remote_state_o) != REM_LOCAL &&
		remote_state_o != REM_LOCAL |-> remote_lamp_o) else $error("remote lamp dark");
endmodule
bind isc_top isc_chk chk_u (.*);

// ### verification/isc_host.sv
// Host computer model issuing decoded commands and character events.
`timescale 1ns/100ps
module isc_host
(
	// Clock.
	input  wire logic        mclk_i,
	// Command and character events.
	output logic             cmd_valid_o,
	output isc_pkg::isc_cmd_t cmd_code_o,
	output logic [7:0]       cmd_value_o,
	output logic             status_clear_o,
	output logic             rx_char_o,
	output logic             tx_valid_o,
	output logic [7:0]       tx_char_o
);
	import isc_pkg::*;
	// Idle host: nothing requested.
	initial
	begin
		{cmd_valid_o, status_clear_o, rx_char_o, tx_valid_o} = 4'h0;
		cmd_code_o = CMD_SET_MASK;
		{cmd_value_o, tx_char_o} = 16'h0000;
	end
	// One command, held for exactly one taking edge, then one idle edge.
	task automatic send_cmd(input isc_cmd_t code, input logic [7:0] value);
		cmd_code_o = code;
		cmd_value_o = value;
		cmd_valid_o = 1'b1;
		@(posedge mclk_i);
		#1;
		cmd_valid_o = 1'b0;
		@(posedge mclk_i);
		#1;
	endtask
	// One-cycle event: 0 clears status, 1 receives, 2 transmits a character.
	task automatic pulse(input int sel, input logic [7:0] c);
		tx_char_o = c;
		status_clear_o = (sel == 0);
		rx_char_o = (sel == 1);
		tx_valid_o = (sel == 2);
		@(posedge mclk_i);
		#1;
		{status_clear_o, rx_char_o, tx_valid_o} = 3'h0;
	endtask
endmodule

// ### verification/isc_top_tb.sv
// Self-checking bench for the status and configuration block.
`timescale 1ns/100ps
module isc_top_tb;
	import isc_pkg::*;
	logic mclk_i = 1'b0, sys_rst_i = 1'b1, ref_double_i = 1'b0;
	logic [7:0] address_switch_bank_i = 8'h00, serial_switch_bank_i = 8'h00, sw;
	logic [KEY_N-1:0] panel_keys_i = '0;
	logic [4:0] cond = 5'h00, sensitivity_o, bus_addr_o;
	logic mag_low_i, no_ref_i, unlocked_i, overload_i, auto_offset_fail_i;
	logic [19:0] ref_freq_i = 20'h0_0000;
	logic cmd_valid_i, status_clear_i, rx_char_i, tx_valid_i, srq_o, bus_addr_ok_o;
	isc_cmd_t cmd_code_i;
	logic [7:0] cmd_value_i, tx_char_i, instrument_status_flags_o, srq_mask_o, tx_data_o;
	isc_res_t dynamic_reserve_o;
	isc_rem_t remote_state_o;
	logic [20:0] bandpass_freq_o;
	logic [16:0] baud_div_o;
	logic debug_echo_o, parity_en_o, parity_odd_o, serial_echo_o, two_stop_o, tx_valid_o;
	logic [2:0] filter_in_lamp_o, filter_out_lamp_o, b;
	logic overload_lamp_o, loop_unlocked_lamp_o, traffic_lamp_o, error_lamp_o, remote_lamp_o;
	int num_errors = 0, checked = 0, cycles = 0, n;
	assign {auto_offset_fail_i, overload_i, unlocked_i, no_ref_i, mag_low_i} = cond;
	isc_top #(.REPEAT_CYCLES(8), .ACT_CYCLES(4), .ERR_CYCLES(6)) dut_u (.*);
	isc_host host_u (.mclk_i(mclk_i), .cmd_valid_o(cmd_valid_i), .cmd_code_o(cmd_code_i),
		.cmd_value_o(cmd_value_i), .status_clear_o(status_clear_i), .rx_char_o(rx_char_i),
		.tx_valid_o(tx_valid_i), .tx_char_o(tx_char_i));
	////////////////////////////////////////////////////////////////
	// Clock and hang guard.
	always #20 mclk_i = ~mclk_i;
	always @(posedge mclk_i)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			num_errors++;
			final_report();
		end
	end
	task automatic final_report();
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge mclk_i);
		#1;
	endtask
	// A key held for k cycles, then released and left to settle.
	task automatic press(input int key, input int k);
		panel_keys_i[key] = 1'b1;
		cyc(k);
		panel_keys_i[key] = 1'b0;
		cyc(4);
	endtask
	////////////////////////////////////////////////////////////////
	// Main sequence of scenarios.
	initial
	begin
		cyc(5);
		sys_rst_i = 1'b0;
		chk("sens", SENS_RST, sensitivity_o);
		chk("mask", MASK_RST, srq_mask_o);
		address_switch_bank_i = 8'hd7;
		cyc(4);
		chk("addr", 5'h17, bus_addr_o);
		chk("addr_ok", 1'b1, bus_addr_ok_o);
		chk("dbg_echo", 1'b1, debug_echo_o);
		address_switch_bank_i = 8'hff;
		cyc(4);
		chk("addr_ok", 1'b0, bus_addr_ok_o);
		chk("dbg_echo", 1'b0, debug_echo_o);
		for (int i = 0; i < 8; i++)
		begin
			b = 3'(i);
			sw = {1'b0, b, b[1], b};
			serial_switch_bank_i = sw;
			n = (i == 0) ? 6 : 7 - i;
			cyc(4);
			chk("baud", 17'(BAUD_BASE_DIV << n), baud_div_o);
			chk("par_en", sw[4], parity_en_o);
			if (sw[4])
				chk("par_odd", sw[3], parity_odd_o);
			chk("echo", !sw[5], serial_echo_o);
			chk("stop2", sw[6], two_stop_o);
		end
		host_u.send_cmd(CMD_SET_MASK, 8'h10);
		cond = 5'h1f;
		cyc(2);
		chk("status", 8'h7d, instrument_status_flags_o);
		chk("srq", 1'b1, srq_o);
		chk("ovl_lamp", 1'b1, overload_lamp_o);
		chk("unl_lamp", 1'b1, loop_unlocked_lamp_o);
		cond = 5'h00;
		cyc(1);
		host_u.pulse(0, 8'h00);
		chk("status", 8'h00, instrument_status_flags_o);
		chk("srq", 1'b0, srq_o);
		host_u.send_cmd(CMD_ILLEGAL, 8'h00);
		chk("bit7", 1'b1, instrument_status_flags_o[7]);
		chk("err_lamp", 1'b1, error_lamp_o);
		host_u.send_cmd(CMD_SET_REMOTE, 8'h03);
		chk("bit1", 1'b1, instrument_status_flags_o[1]);
		host_u.send_cmd(CMD_SET_REMOTE, 8'h02);
		press(KEY_DISP_UP, 3);
		chk("lockout", REM_LOCKOUT, remote_state_o);
		chk("rem_lamp", 1'b1, remote_lamp_o);
		press(KEY_SENS_DN, 3);
		chk("sens", 5'h18, sensitivity_o);
		host_u.send_cmd(CMD_SET_REMOTE, 8'h01);
		press(KEY_SENS_DN, 3);
		chk("sens", 5'h18, sensitivity_o);
		press(KEY_DISP_UP, 3);
		chk("local", REM_LOCAL, remote_state_o);
		chk("rem_lamp", 1'b0, remote_lamp_o);
		host_u.send_cmd(CMD_SET_REMOTE, 8'h00);
		press(KEY_SENS_DN, 3);
		chk("sens", 5'h17, sensitivity_o);
		press(KEY_SENS_DN, 14);
		chk("sens", 5'h15, sensitivity_o);
		host_u.send_cmd(CMD_SET_SENS, 8'(SENS_MIN));
		chk("reserve", RES_NORM, dynamic_reserve_o);
		press(KEY_SENS_DN, 3);
		chk("sens", SENS_MIN, sensitivity_o);
		host_u.send_cmd(CMD_SET_RESERVE, 8'h02);
		chk("reserve", RES_HIGH, dynamic_reserve_o);
		host_u.send_cmd(CMD_SET_SENS, 8'(SENS_MAX));
		chk("reserve", RES_LOW, dynamic_reserve_o);
		host_u.pulse(0, 8'h00);
		host_u.send_cmd(CMD_SET_RESERVE, 8'h01);
		chk("reserve", RES_LOW, dynamic_reserve_o);
		chk("bit1", 1'b1, instrument_status_flags_o[1]);
		press(KEY_RES_UP, 3);
		chk("reserve", RES_LOW, dynamic_reserve_o);
		host_u.send_cmd(CMD_SET_SENS, 8'(HIGH_MAX));
		press(KEY_RES_UP, 3);
		press(KEY_RES_UP, 3);
		chk("reserve", RES_HIGH, dynamic_reserve_o);
		press(KEY_SENS_UP, 3);
		chk("sens", 5'h13, sensitivity_o);
		chk("reserve", RES_NORM, dynamic_reserve_o);
		press(KEY_RES_DN, 3);
		chk("reserve", RES_LOW, dynamic_reserve_o);
		press(KEY_FILT0, 3);
		chk("filt_in", 3'h1, filter_in_lamp_o);
		press(KEY_FILT0 + 2, 3);
		chk("filt_out", 3'h2, filter_out_lamp_o);
		press(KEY_FILT0, 3);
		chk("filt_in", 3'h4, filter_in_lamp_o);
		ref_freq_i = 20'h0_03e8;
		cyc(3);
		chk("bandpass", 21'h00_03e8, bandpass_freq_o);
		ref_double_i = 1'b1;
		cyc(3);
		chk("bandpass", 21'h00_07d0, bandpass_freq_o);
		host_u.pulse(2, 8'hc1);
		chk("tx_data", 8'h41, tx_data_o);
		cyc(1);
		chk("traffic", 1'b1, traffic_lamp_o);
		host_u.pulse(1, 8'h00);
		cyc(2);
		final_report();
	end
endmodule
